// ===== logic/cipher_ctl.sv
/*
   Control and status logic of the 128-bit block cipher window: status,
   control and mirror registers, key and state storage, chaining, and the
   handshake to a separate cipher core.
   Assumes the serial slave presents byte accesses on CORE_CLK and shifts
   RDATA out one byte later; the core answers each start with one done pulse.
*/
// Notes on behaviour
// [RQ1] Status register is read-only
// [RQ2] Bit 7 flags errors; resets to 0
// [RQ3] Bit 0 shows operation completed
// [RQ4] Control access while busy aborts operation
// [RQ5] Software polls status, avoids control while busy
// [RQ6] Writing start bit 1 starts operation
// [RQ7] Start bit resets to 0, idle
// [RQ8] Mode bits 6:4 codebook, key, chaining
// [RQ9] Bit 3 direction, decrypt codebook only
// [RQ10] Mirror address behaves as control register
// [RQ11] Burst may end with mirror start write
// [RQ12] Window holds key or state by mode
// [RQ13] Chaining XORs plaintext with last ciphertext
// [RQ14] Writes return previous content one byte later
// [RQ15] Deepest sleep resets all registers
// [RQ16] Done clears on start, sets with result
// [RQ17] Reserved bits read 0, ignore writes
`timescale 1ns/1ps
module cipher_ctl
(
   // Clock and reset
   input  wire logic                      CORE_CLK,
   input  wire logic                      NRST,
   // Sleep control
   input  wire logic                      DEEPEST_SLEEP_STATE,
   // Byte access from the serial slave
   input  wire cipher_ctl_pkg::byte_acc_s ACC,
   output logic [7:0]                     RDATA,
   // Cipher core handshake
   output cipher_ctl_pkg::core_req_s      CORE_REQ,
   input  wire cipher_ctl_pkg::core_rsp_s CORE_RSP
);
   import cipher_ctl_pkg::*;

   // Whole state of the block
   typedef struct packed
   {
      logic [2:0] mode;       // Mode field
      logic       dir;        // Direction field
      logic       busy;       // Operation in progress
      logic       done;       // Completion flag
      logic       err;        // Error flag
      logic [4:0] rd_cnt;     // State bytes read in this access
      logic [7:0] rdata;      // Read / previous-content byte
      block_t     key;        // Key store
      block_t     state;      // Data state
      block_t     chain;      // Last ciphertext for chaining
      core_req_s  req;        // Registered core request
   } regs_s;

   typedef enum logic [1:0]
   {
      SEL_NONE,
      SEL_STATUS,
      SEL_CONTROL,
      SEL_WINDOW
   } sel_e;

   regs_s cur_ff;             // Registered state
   regs_s nxt_cur;            // Next state
   sel_e  sel;                // Decoded target of the access
   logic  acc_any;            // Read or write this cycle

   // Decode an address into its register group
   function automatic sel_e decode(input logic [7:0] a);
      sel_e s;
      s = SEL_NONE;
      if (a == ADDR_STATUS)
         s = SEL_STATUS;
      else if ((a == ADDR_CONTROL) || (a == ADDR_MIRROR))   // [RQ10]
         s = SEL_CONTROL;
      else if ((a >= ADDR_STATE_LO) && (a <= ADDR_STATE_HI))
         s = SEL_WINDOW;
      return s;
   endfunction

   // Byte index inside the 128-bit window
   function automatic logic [3:0] win_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - ADDR_STATE_LO;
      return d[3:0];
   endfunction

   // Readable image of the control register; start bit is write-only
   function automatic logic [7:0] ctrl_image(input regs_s r);
      logic [7:0] v;
      v = BYTE_ZERO;                                   // [RQ17]
      v[CTRL_MODE_HI:CTRL_MODE_LO] = r.mode;
      v[CTRL_DIR_BIT] = r.dir;
      return v;
   endfunction

   assign sel     = decode(ACC.addr);
   assign acc_any = ACC.wr | ACC.rd;

   // Next-state logic
   always_comb
   begin
      logic [7:0] stat;        // Status image
      logic [3:0] idx;         // Window byte index
      logic       key_sel;     // Window holds key
      stat    = STATUS_RESET;
      idx     = win_idx(ACC.addr);
      nxt_cur = cur_ff;
      key_sel = (cur_ff.mode == MODE_KEYLOAD);         // [RQ12]

      // Start and abort are single-cycle pulses
      nxt_cur.req.start = 1'b0;
      nxt_cur.req.abort = 1'b0;

      // Status image, reserved bits zero
      stat[STATUS_ERR_BIT]  = cur_ff.err;              // [RQ2]
      stat[STATUS_DONE_BIT] = cur_ff.done;             // [RQ3]

      // Core completion writes the result back to the state, except after a key load
      if (CORE_RSP.done && cur_ff.busy)
      begin
         nxt_cur.busy = 1'b0;
         if (cur_ff.req.mode != MODE_KEYLOAD)
         begin
            nxt_cur.state = CORE_RSP.result;
            nxt_cur.chain = CORE_RSP.result;           // [RQ13]
         end
         nxt_cur.done = 1'b1;                          // [RQ16]
      end

      // Every access returns the prior content of its location;
      // on a write the slave shifts it out one byte later
      if (acc_any)
      begin
         case (sel)
            SEL_STATUS:  nxt_cur.rdata = stat;         // [RQ14]
            SEL_CONTROL: nxt_cur.rdata = ctrl_image(cur_ff);
            SEL_WINDOW:  nxt_cur.rdata = key_sel ? cur_ff.key[idx] : cur_ff.state[idx];
            default:     nxt_cur.rdata = BYTE_ZERO;
         endcase
      end

      // Register group behaviour
      case (sel)
         SEL_STATUS:
         begin
            // Writes are dropped; status only follows hardware events
            nxt_cur.rdata = acc_any ? stat : nxt_cur.rdata;   // [RQ1]
         end
         SEL_CONTROL:
         begin
            if (acc_any && cur_ff.busy)
            begin
               // Touching control mid-run kills the run; the write is
               // discarded so a stray start cannot relaunch on half data
               nxt_cur.busy      = 1'b0;               // [RQ4]
               nxt_cur.req.abort = 1'b1;               // [RQ4]
               nxt_cur.err       = 1'b1;               // [RQ2]
            end
            else if (ACC.wr)
            begin
               nxt_cur.mode = ACC.wdata[CTRL_MODE_HI:CTRL_MODE_LO];   // [RQ8]
               nxt_cur.dir  = ACC.wdata[CTRL_DIR_BIT];                // [RQ9]
               if (ACC.wdata[CTRL_START_BIT])          // [RQ6]
               begin
                  nxt_cur.busy      = 1'b1;
                  nxt_cur.done      = 1'b0;            // [RQ16]
                  nxt_cur.req.start = 1'b1;
                  nxt_cur.req.mode  = ACC.wdata[CTRL_MODE_HI:CTRL_MODE_LO];
                  // Decrypt exists for codebook mode only
                  nxt_cur.req.dir   = ACC.wdata[CTRL_DIR_BIT] &&
                                      (ACC.wdata[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_CODEBOOK); // [RQ9]
                  nxt_cur.req.key   = cur_ff.key;
                  if (ACC.wdata[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_CHAIN)
                     nxt_cur.req.data = cur_ff.state ^ cur_ff.chain;   // [RQ13]
                  else if (ACC.wdata[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_KEYLOAD)
                     nxt_cur.req.data = cur_ff.key;
                  else
                     nxt_cur.req.data = cur_ff.state;
               end
            end
         end
         SEL_WINDOW:
         begin
            if (ACC.wr)
            begin
               // Window write overwrites the key in key-load mode, else the previous result
               if (key_sel)
                  nxt_cur.key[idx] = ACC.wdata;        // [RQ12]
               else
                  nxt_cur.state[idx] = ACC.wdata;      // [RQ12]
            end
            else if (ACC.rd && (cur_ff.rd_cnt != STATE_BYTES))
            begin
               nxt_cur.rd_cnt = cur_ff.rd_cnt + COUNT_ONE;
            end
         end
         default:
         begin
            // Outside the window: nothing stored
         end
      endcase

      // A partial read of the 128-bit state is flagged at access end;
      // the count only sees plain reads, so fast writes do not trip it
      if (ACC.acc_end)
      begin
         nxt_cur.rd_cnt = COUNT_ZERO;
         if ((cur_ff.rd_cnt != COUNT_ZERO) && (cur_ff.rd_cnt < STATE_BYTES))
            nxt_cur.err = 1'b1;                        // [RQ2]
      end
   end

   // State register; deepest sleep acts like reset
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST || DEEPEST_SLEEP_STATE)                // [RQ15]
      begin
         cur_ff      <= '0;                            // [RQ7]
         cur_ff.mode <= CONTROL_RESET[CTRL_MODE_HI:CTRL_MODE_LO];   // [RQ8]
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs straight from the state register
   assign RDATA    = cur_ff.rdata;
   assign CORE_REQ = cur_ff.req;

endmodule

// ===== shared/cipher_ctl_pkg.sv
/*
   Constants and carrier types for the cipher control and status block:
   address map of the fast memory window, field positions, reset values
   and the structs that carry byte accesses and core handshakes.
   Assumes a byte-wide access port fed by the serial slave on the same clock.
*/
package cipher_ctl_pkg;

   // Byte address map of the security window
   localparam logic [7:0] ADDR_STATUS     = 8'h82;
   localparam logic [7:0] ADDR_CONTROL    = 8'h83;
   localparam logic [7:0] ADDR_STATE_LO   = 8'h84;
   localparam logic [7:0] ADDR_STATE_HI   = 8'h93;
   localparam logic [7:0] ADDR_MIRROR     = 8'h94;

   // Field positions
   localparam int STATUS_ERR_BIT  = 7;
   localparam int STATUS_DONE_BIT = 0;
   localparam int CTRL_START_BIT  = 7;
   localparam int CTRL_MODE_HI    = 6;
   localparam int CTRL_MODE_LO    = 4;
   localparam int CTRL_DIR_BIT    = 3;

   // Reset and fixed values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [4:0] STATE_BYTES   = 5'h10;   // 128 bits
   localparam logic [4:0] COUNT_ZERO    = 5'h00;
   localparam logic [4:0] COUNT_ONE     = 5'h01;

   // Mode field encodings
   typedef enum logic [2:0]
   {
      MODE_CODEBOOK = 3'h0,
      MODE_KEYLOAD  = 3'h1,
      MODE_CHAIN    = 3'h2
   } cipher_mode_e;

   typedef logic [15:0][7:0] block_t;   // 128-bit block, byte 0 at low address

   // One byte access from the serial slave
   typedef struct packed
   {
      logic       wr;        // Write strobe, one cycle
      logic       rd;        // Read strobe, one cycle
      logic       acc_end;   // Pulse at end of a whole serial access
      logic [7:0] addr;      // Byte address
      logic [7:0] wdata;     // Write data
   } byte_acc_s;

   // Request to the cipher core
   typedef struct packed
   {
      logic       start;     // One-cycle start pulse
      logic       abort;     // One-cycle abort pulse
      logic [2:0] mode;      // Mode code
      logic       dir;       // 1 = decrypt
      block_t     key;       // Key
      block_t     data;      // Input block
   } core_req_s;

   // Answer from the cipher core
   typedef struct packed
   {
      logic       done;      // One-cycle completion pulse
      block_t     result;    // Output block
   } core_rsp_s;

endpackage

// ===== verification/block_cipher_control_status_tb.sv
/*
   Testbench for the cipher control block with a model core.
   Assumes inputs driven at the falling edge of a 200 MHz clock.
*/
`timescale 1ns/1ps
module block_cipher_control_status_tb;
   import cipher_ctl_pkg::*;
   logic       core_clk = 1'b0;
   logic       nrst     = 1'b0;
   logic       sleep    = 1'b0;
   byte_acc_s  acc      = '0;
   logic [7:0] rdata;
   core_req_s  req;
   core_rsp_s  rsp;
   int         n_errors = 0;
   int         n_compared = 0;
   int         cyc = 0;
   int         n_abort = 0;
   int         i;
   block_t     k, p, p2, c;
   always #2.5 core_clk = ~core_clk;
   cipher_ctl cipher_ctl_inst (.CORE_CLK(core_clk), .NRST(nrst), .DEEPEST_SLEEP_STATE(sleep),
      .ACC(acc), .RDATA(rdata), .CORE_REQ(req), .CORE_RSP(rsp));
   cipher_core_model cipher_core_model_inst (.clk(core_clk), .nrst(nrst), .req(req), .rsp(rsp));
   task automatic stop_test();
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One byte access; an idle cycle follows so strobes never re-rise in one step
   task automatic acc1(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
      input logic ce);
      acc.wr    = w;
      acc.rd    = ~w;
      acc.addr  = a;
      acc.wdata = d;
      @(negedge core_clk);
      acc.wr = 1'b0;
      acc.rd = 1'b0;
      if (ce)
         chk("rdata", 128'(rdata), 128'(e));
      @(negedge core_clk);
   endtask
   task automatic end_access();
      acc.acc_end = 1'b1;
      @(negedge core_clk);
      acc.acc_end = 1'b0;
      @(negedge core_clk);
   endtask
   // Cut a hang short; count aborts seen, sampled mid-cycle so the
   // registered abort pulse is settled and counted exactly once
   always @(negedge core_clk)
   begin
      cyc++;
      if (req.abort === 1'b1)
         n_abort++;
      if (cyc == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end
   initial
   begin
      for (i = 0; i < 16; i++)
      begin
         k[i]  = 8'(i);
         p[i]  = 8'(8'hA0 + i);
         p2[i] = 8'(8'h50 + i);
      end
      c = p ^ k;
      repeat (2) @(negedge core_clk);
      nrst = 1'b1;
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h00, 1'b1);
      acc1(1'b0, ADDR_CONTROL, 8'h00, 8'h00, 1'b1);
      acc1(1'b1, ADDR_STATUS, 8'hFF, 8'h00, 1'b1);
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h00, 1'b1);
      acc1(1'b1, ADDR_CONTROL, 8'h1F, 8'h00, 1'b1);
      acc1(1'b0, ADDR_MIRROR, 8'h00, 8'h18, 1'b1);
      acc1(1'b1, ADDR_CONTROL, 8'h10, 8'h18, 1'b1);
      for (i = 0; i < 16; i++)
         acc1(1'b1, 8'(ADDR_STATE_LO + i), k[i], 8'h00, 1'b0);
      acc1(1'b1, ADDR_CONTROL, 8'h00, 8'h00, 1'b0);
      for (i = 0; i < 16; i++)
         acc1(1'b1, 8'(ADDR_STATE_LO + i), p[i], 8'h00, 1'b0);
      acc1(1'b1, ADDR_MIRROR, 8'h80, 8'h00, 1'b0);
      chk("key", req.key, k);
      chk("data", req.data, p);
      for (i = 0; i < 100 && rsp.done !== 1'b1; i++)
         @(negedge core_clk);
      @(negedge core_clk);
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h01, 1'b1);
      for (i = 0; i < 16; i++)
         acc1(1'b0, 8'(ADDR_STATE_LO + i), 8'h00, c[i], 1'b1);
      end_access();
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h01, 1'b1);
      acc1(1'b1, ADDR_CONTROL, 8'h20, 8'h00, 1'b0);
      for (i = 0; i < 16; i++)
         acc1(1'b1, 8'(ADDR_STATE_LO + i), p2[i], c[i], 1'b1);
      acc1(1'b1, ADDR_MIRROR, 8'hA8, 8'h00, 1'b0);
      chk("chain", req.data, p2 ^ c);
      chk("dir", 128'(req.dir), 128'(1'b0));
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h00, 1'b1);
      acc1(1'b0, ADDR_CONTROL, 8'h00, 8'h00, 1'b0);
      chk("aborts", 128'(n_abort), 128'(1));
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h80, 1'b1);
      sleep = 1'b1;
      @(negedge core_clk);
      sleep = 1'b0;
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h00, 1'b1);
      acc1(1'b0, ADDR_CONTROL, 8'h00, 8'h00, 1'b1);
      for (i = 0; i < 3; i++)
         acc1(1'b0, 8'(ADDR_STATE_LO + i), 8'h00, 8'h00, 1'b0);
      end_access();
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h80, 1'b1);
      // Key load, then a codebook decrypt: both codes must reach the core
      acc1(1'b1, ADDR_CONTROL, 8'h10, 8'h00, 1'b1);
      for (i = 0; i < 16; i++)
         acc1(1'b1, 8'(ADDR_STATE_LO + i), k[i], 8'h00, 1'b1);
      acc1(1'b1, ADDR_MIRROR, 8'h98, 8'h10, 1'b1);
      chk("key mode", 128'(req.mode), 128'(MODE_KEYLOAD));
      chk("key dir", 128'(req.dir), 128'(1'b0));
      chk("key data", req.data, k);
      for (i = 0; i < 100 && rsp.done !== 1'b1; i++)
         @(negedge core_clk);
      @(negedge core_clk);
      acc1(1'b0, ADDR_STATUS, 8'h00, 8'h81, 1'b1);
      acc1(1'b1, ADDR_CONTROL, 8'h88, 8'h18, 1'b1);
      chk("ecb mode", 128'(req.mode), 128'(MODE_CODEBOOK));
      chk("ecb dir", 128'(req.dir), 128'(1'b1));
      chk("ecb key", req.key, k);
      chk("ecb data", req.data, 128'h0);
      stop_test();
   end
endmodule

// ===== verification/cipher_core_model.sv
/*
   Behavioural cipher core: answers each start not aborted first with one done pulse
   after LAT cycles, result = data XOR key. Assumes the block's request struct.
*/
`timescale 1ns/1ps
module cipher_core_model
#(
   parameter int LAT = 20   // Slow enough to abort in flight
)
(
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire cipher_ctl_pkg::core_req_s req,
   output cipher_ctl_pkg::core_rsp_s      rsp
);
   import cipher_ctl_pkg::*;
   int     cnt;    // Cycles left before done
   block_t calc;   // Result held until done
   // Result toggles outside done so stale values never pass
   always_ff @(posedge clk)
   begin
      rsp.done   <= 1'b0;
      rsp.result <= ~rsp.result;
      if (!nrst || req.abort)
      begin
         cnt        <= 0;
         rsp.result <= '0;
      end
      else if (req.start)
      begin
         cnt  <= LAT;
         calc <= req.data ^ req.key;
      end
      else if (cnt == 1)
      begin
         cnt        <= 0;
         rsp.done   <= 1'b1;
         rsp.result <= calc;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule

// ===== verification/cipher_ctl_properties.sv
/*
   Port checker for the cipher control block.
   Assumes a single clock; NRST low or sleep high resets the block.
*/
`timescale 1ns/1ps
module cipher_ctl_properties
(
   // Clock and reset
   input wire logic                      CORE_CLK,
   input wire logic                      NRST,
   input wire logic                      DEEPEST_SLEEP_STATE,
   // Watched traffic
   input wire cipher_ctl_pkg::byte_acc_s ACC,
   input wire logic [7:0]                RDATA,
   input wire cipher_ctl_pkg::core_req_s CORE_REQ,
   input wire cipher_ctl_pkg::core_rsp_s CORE_RSP
);
   import cipher_ctl_pkg::*;
   logic busy_ff;   // Operation in flight, seen from the ports
   logic busy;      // Includes the start cycle itself
   logic ctl_hit;   // Access to control or its mirror
   assign busy    = (busy_ff || CORE_REQ.start) && !CORE_REQ.abort;
   assign ctl_hit = (ACC.wr || ACC.rd) && (ACC.addr == ADDR_CONTROL || ACC.addr == ADDR_MIRROR);
   // Track start until done or abort; done at the same edge as an access wins
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST || DEEPEST_SLEEP_STATE)
         busy_ff <= 1'b0;
      else
         busy_ff <= busy && !CORE_RSP.done;
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST || DEEPEST_SLEEP_STATE);
   a_start_on_write: assert property (ctl_hit && ACC.wr && ACC.wdata[7] |=> CORE_REQ.start || CORE_REQ.abort)
      else $error("start write gave no start");
   a_no_idle_start: assert property (ctl_hit && ACC.wr && !ACC.wdata[7] |=> !CORE_REQ.start)
      else $error("start without start bit");
   a_decrypt_codebook: assert property (CORE_REQ.start |-> !CORE_REQ.dir || CORE_REQ.mode == MODE_CODEBOOK)
      else $error("decrypt outside codebook");
   a_abort_busy: assert property (busy && ctl_hit && !CORE_RSP.done |=> CORE_REQ.abort && !CORE_REQ.start)
      else $error("control access did not abort");
   a_reset_clear: assert property ($rose(NRST) |-> RDATA == 8'h00 && !CORE_REQ.start && !CORE_REQ.abort)
      else $error("outputs not clear after reset");
   a_sleep_clear: assert property ($fell(DEEPEST_SLEEP_STATE) |-> CORE_REQ == '0 && RDATA == 8'h00)
      else $error("outputs not clear after sleep");
   a_status_fmt: assert property (ACC.rd && ACC.addr == ADDR_STATUS |=> RDATA[6:1] == 6'h00)
      else $error("status reserved bits set");
   a_ctrl_fmt: assert property (ctl_hit && ACC.rd |=> RDATA[7] == 1'b0 && RDATA[2:0] == 3'h0)
      else $error("control reads bad bits");
endmodule
bind cipher_ctl cipher_ctl_properties cipher_ctl_properties_inst (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .DEEPEST_SLEEP_STATE(DEEPEST_SLEEP_STATE), .ACC(ACC), .RDATA(RDATA), .CORE_REQ(CORE_REQ), .CORE_RSP(CORE_RSP));
